// ==== verilog/bsc_pkg.sv ====
// Package: register map, bit positions and timing constants for the system control bank
package bsc_pkg;

  // ****************************************************************
  // Register offsets (byte addresses on the plain register port)
  // ****************************************************************
  localparam logic [5:0] RstCtlOff = 6'h04;
  localparam logic [5:0] PwrStatOff = 6'h05;
  localparam logic [5:0] ScratchOneOff = 6'h06;
  localparam logic [5:0] ClkRptOff = 6'h07;
  localparam logic [5:0] ScratchTwoOff = 6'h08;
  localparam logic [5:0] SeqCtlOff = 6'h10;
  localparam logic [5:0] SeqStatOff = 6'h11;

  // ****************************************************************
  // Field positions, bit 0 is the most significant bit of a byte
  // ****************************************************************
  localparam int FullResetBit = 7;        // Documented bit 0
  localparam int SlotSelBit = 3;          // Documented bit 4
  localparam int PhyRelBit = 2;           // Documented bit 5
  localparam int LbRelBit = 1;            // Documented bit 6
  localparam int GenRelBit = 0;           // Documented bit 7
  localparam int MainGoodBit = 7;
  localparam int Core0GoodBit = 6;
  localparam int SerialGoodBit = 3;
  localparam int V12GoodBit = 2;
  localparam int Br18GoodBit = 1;
  localparam int MemGoodBit = 0;
  localparam int WdEnBit = 3;             // Documented bit 4
  localparam int PwrOffBit = 1;           // Documented bit 6
  localparam int GoBit = 0;               // Documented bit 7
  localparam int BusyBit = 0;             // Documented bit 7

  // Writable bit masks, reserved positions stay zero
  localparam logic [7:0] RstCtlMask = 8'h8f;
  localparam logic [7:0] SeqCtlMask = 8'h0b;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RstCtlReset = 8'h8f;
  localparam logic [7:0] ScratchReset = 8'h00;
  localparam logic [7:0] SeqCtlReset = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int WdLog2Cycles = 29;
  localparam int SeqRunCycles = 16;

  // Register port request bundle
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bsc_req_t;

  // Live board levels after synchronisation
  typedef struct packed {
    logic mainGood;
    logic core0Good;
    logic serialGood;
    logic v12Good;
    logic br18Good;
    logic [1:0] memGood;
    logic [2:0] memClkSel;
    logic [2:0] sysClkSel;
  } bsc_pins_t;

endpackage

// ==== verilog/bsc_sync.sv ====
// Two-flop synchroniser for a vector of board-level inputs
`timescale 1ns/1ps
module bsc_sync #(
  parameter int Width = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [Width-1:0] asyncIn,
  output logic [Width-1:0] syncOut
);

  logic [Width-1:0] meta_q;

  // First stage is read only by the second stage
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q <= '0;
      syncOut <= '0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule

// ==== verilog/bsc_regs.sv ====
// System control register bank: resets, power status, scratch, watchdog and sequencer control
//
// Overview of operation
// - Writing zero to full-reset bit starts reset
// - Full-reset bit restored by that reset or by a write of one
// - Other reset bits hold until software rewrites
// - Reset register reads return stored contents
// - Slot select bit adds slot interrupt reset
// - Bits 5-7 drive PHY, bus, general resets
// - Register resets ORed with sequencer reset outputs
// - Slot select bit defaults to reset term
// - Power status reports live supply good levels
// - Memory good bit is AND of both
// - Scratch registers survive debug and watchdog resets
// - Speed register reports clock switch settings
// - Watchdog resets system after 2^29 cycles
// - Clearing watchdog enable stops pending timeout
// - Power-off bit forces board power off
// - Power-off resets zero, clearing never restores
// - No software path forces power on
// - Start bit launches sequencer, idle while zero
// - Sequencer runs once until start cleared
// - Busy bit reflects sequencer busy state
`timescale 1ns/1ps
module bsc_regs #(
  parameter int WdCycles = 2 ** bsc_pkg::WdLog2Cycles,
  parameter int SeqCycles = bsc_pkg::SeqRunCycles
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic chassisRst,
  input wire bsc_pkg::bsc_req_t req,
  output logic [7:0] rdData,
  input wire logic mainSupplyGood,
  input wire logic core0SupplyGood,
  input wire logic serialLinkSupplyGood,
  input wire logic supply1v2Good,
  input wire logic bridge1v8Good,
  input wire logic [1:0] memorySupplyGood,
  input wire logic [2:0] memoryClockSetting,
  input wire logic [2:0] systemClockSetting,
  input wire logic remoteSlotInt_n,
  input wire logic seqPhyReset,
  input wire logic seqLocalBusReset,
  input wire logic seqGeneralReset,
  output logic fullSystemReset,
  output logic slotIntReset,
  output logic phyReset_n,
  output logic localBusReset_n,
  output logic generalReset_n,
  output logic forcePowerOff,
  output logic seqStart,
  output logic seqBusy
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  bsc_pkg::bsc_pins_t pinsRaw;
  bsc_pkg::bsc_pins_t pins;
  logic slotIntSync;
  logic [2:0] seqRstSync;

  assign pinsRaw = '{mainGood: mainSupplyGood, core0Good: core0SupplyGood,
                     serialGood: serialLinkSupplyGood, v12Good: supply1v2Good,
                     br18Good: bridge1v8Good, memGood: memorySupplyGood,
                     memClkSel: memoryClockSetting, sysClkSel: systemClockSetting};

  // Every board level goes through two flops before any logic sees it; the slot
  // interrupt is inverted first so that the cleared flops read as idle, not asserted
  bsc_sync #(
    .Width($bits(bsc_pkg::bsc_pins_t) + 4)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .asyncIn({pinsRaw, ~remoteSlotInt_n, seqPhyReset, seqLocalBusReset, seqGeneralReset}),
    .syncOut({pins, slotIntSync, seqRstSync})
  );

  // Sequencer resets land as [2] phy, [1] local bus, [0] general
  logic seqPhyS;
  logic seqLbS;
  logic seqGenS;
  assign seqPhyS = seqRstSync[2];
  assign seqLbS = seqRstSync[1];
  assign seqGenS = seqRstSync[0];

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic wrRst;
  logic wrScr1;
  logic wrScr2;
  logic wrSeq;
  assign wrRst = req.wr && (req.addr == bsc_pkg::RstCtlOff);
  assign wrScr1 = req.wr && (req.addr == bsc_pkg::ScratchOneOff);
  assign wrScr2 = req.wr && (req.addr == bsc_pkg::ScratchTwoOff);
  assign wrSeq = req.wr && (req.addr == bsc_pkg::SeqCtlOff);

  // ****************************************************************
  // Reset control register
  // ****************************************************************
  logic [7:0] rstCtl_q;
  logic [7:0] rstCtl_d;
  logic wdFire;
  logic fullRstReq;

  // Full reset requested by a zero in the top bit or by the watchdog
  assign fullRstReq = ~rstCtl_q[bsc_pkg::FullResetBit] | wdFire;

  // Writes take only defined bits; the full-reset bit comes back via the reset itself or a write of one,
  // and that restore wins over a write in the same cycle while the other bits still land
  logic [7:0] restoreBit;
  assign restoreBit = fullSystemReset ? (8'h01 << bsc_pkg::FullResetBit) : 8'h00;
  assign rstCtl_d = (wrRst ? (req.wdata & bsc_pkg::RstCtlMask) : rstCtl_q) |
                    restoreBit;

  // Reset value has the slot select set so a remote system can recover the board
  always_ff @(posedge mclk) begin
    if (rst) begin
      rstCtl_q <= bsc_pkg::RstCtlReset;
    end else begin
      rstCtl_q <= rstCtl_d;
    end
  end

  // Drive the reset pulse one cycle; it then restores the register bit
  always_ff @(posedge mclk) begin
    if (rst) begin
      fullSystemReset <= 1'b0;
    end else begin
      fullSystemReset <= fullRstReq && !fullSystemReset;
    end
  end

  // ****************************************************************
  // Reset outputs
  // ****************************************************************
  logic slotTerm;
  assign slotTerm = rstCtl_q[bsc_pkg::SlotSelBit] & slotIntSync;

  // PHY, local bus and general resets are asserted by either register or sequencer; slot reset needs select and interrupt
  always_ff @(posedge mclk) begin
    if (rst) begin
      slotIntReset <= 1'b0;
      phyReset_n <= 1'b0;
      localBusReset_n <= 1'b0;
      generalReset_n <= 1'b0;
    end else begin
      slotIntReset <= slotTerm;
      phyReset_n <= ~(~rstCtl_q[bsc_pkg::PhyRelBit] | seqPhyS);
      localBusReset_n <= ~(~rstCtl_q[bsc_pkg::LbRelBit] | seqLbS);
      generalReset_n <= ~(~rstCtl_q[bsc_pkg::GenRelBit] | seqGenS);
    end
  end

  // ****************************************************************
  // Scratch registers
  // ****************************************************************
  logic [7:0] scr1_q;
  logic [7:0] scr2_q;

  // Only power-on or chassis reset clears them, not watchdog or debug resets
  always_ff @(posedge mclk) begin
    if (rst || chassisRst) begin
      scr1_q <= bsc_pkg::ScratchReset;
      scr2_q <= bsc_pkg::ScratchReset;
    end else begin
      if (wrScr1) begin
        scr1_q <= req.wdata;
      end
      if (wrScr2) begin
        scr2_q <= req.wdata;
      end
    end
  end

  // ****************************************************************
  // Sequencer control, watchdog and power-off
  // ****************************************************************
  logic [7:0] seqCtl_q;
  logic [7:0] seqCtl_d;
  assign seqCtl_d = wrSeq ? (req.wdata & bsc_pkg::SeqCtlMask) : seqCtl_q;

  // Power-off only clears by write; it never forces power on
  always_ff @(posedge mclk) begin
    if (rst) begin
      seqCtl_q <= bsc_pkg::SeqCtlReset;
    end else begin
      seqCtl_q <= seqCtl_d;
    end
  end

  // Forced off overrides any switch or power management event upstream
  always_ff @(posedge mclk) begin
    if (rst) begin
      forcePowerOff <= 1'b0;
    end else begin
      forcePowerOff <= seqCtl_q[bsc_pkg::PwrOffBit];
    end
  end

  // Watchdog counter; a cleared enable zeroes it at once
  logic [bsc_pkg::WdLog2Cycles:0] wdCnt_q;
  assign wdFire = seqCtl_q[bsc_pkg::WdEnBit] && (wdCnt_q == 30'(WdCycles - 1));

  always_ff @(posedge mclk) begin
    if (rst || !seqCtl_q[bsc_pkg::WdEnBit] || wdFire) begin
      wdCnt_q <= '0;
    end else begin
      wdCnt_q <= wdCnt_q + 30'h1;
    end
  end

  // ****************************************************************
  // Configuration sequencer
  // ****************************************************************
  typedef enum logic [1:0] {SeqIdle, SeqRun, SeqDone} bsc_seq_t;
  bsc_seq_t seqSt_q;
  bsc_seq_t seqSt_d;
  logic [7:0] seqCnt_q;
  logic goBit;
  logic runEnd;
  assign goBit = seqCtl_q[bsc_pkg::GoBit];
  assign runEnd = seqCnt_q == 8'(SeqCycles - 1);

  // One run per start; must see the start bit low before another
  always_comb begin
    seqSt_d = seqSt_q;
    case (seqSt_q)
      SeqIdle: begin
        if (goBit) begin
          seqSt_d = SeqRun;
        end
      end
      SeqRun: begin
        if (runEnd) begin
          seqSt_d = SeqDone;
        end
      end
      SeqDone: begin
        if (!goBit) begin
          seqSt_d = SeqIdle;
        end
      end
      default: begin
        seqSt_d = SeqIdle;
      end
    endcase
  end

  // State, run length and registered status outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      seqSt_q <= SeqIdle;
      seqCnt_q <= 8'h00;
      seqBusy <= 1'b0;
      seqStart <= 1'b0;
    end else begin
      seqSt_q <= seqSt_d;
      seqCnt_q <= (seqSt_d == SeqRun && seqSt_q == SeqRun) ? seqCnt_q + 8'h01 : 8'h00;
      seqBusy <= seqSt_d == SeqRun;
      seqStart <= seqSt_q == SeqIdle && goBit;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [7:0] pwrStat;
  logic [7:0] clkRpt;
  logic [7:0] seqStat;
  logic [7:0] rdMux;
  assign pwrStat = {pins.mainGood, pins.core0Good, 2'b00, pins.serialGood,
                    pins.v12Good, pins.br18Good, &pins.memGood};
  assign clkRpt = {2'b00, pins.memClkSel, pins.sysClkSel};
  assign seqStat = {7'h00, seqBusy};

  // Unmapped addresses answer zero
  assign rdMux = (req.addr == bsc_pkg::RstCtlOff) ? rstCtl_q :
                 (req.addr == bsc_pkg::PwrStatOff) ? pwrStat :
                 (req.addr == bsc_pkg::ScratchOneOff) ? scr1_q :
                 (req.addr == bsc_pkg::ClkRptOff) ? clkRpt :
                 (req.addr == bsc_pkg::ScratchTwoOff) ? scr2_q :
                 (req.addr == bsc_pkg::SeqCtlOff) ? seqCtl_q :
                 (req.addr == bsc_pkg::SeqStatOff) ? seqStat : 8'h00;

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdData <= 8'h00;
    end else begin
      rdData <= req.rd ? rdMux : 8'h00;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_full_reset_start: assert property (@(posedge mclk) disable iff (rst)
    (wrRst && !req.wdata[bsc_pkg::FullResetBit] && !fullSystemReset) |=> ##1 fullSystemReset)
    else $error("full reset not started");
  a_full_bit_restore: assert property (@(posedge mclk) disable iff (rst)
    fullSystemReset && !wrRst |=> rstCtl_q[bsc_pkg::FullResetBit])
    else $error("full reset bit not restored");
  a_reset_bits_hold: assert property (@(posedge mclk) disable iff (rst)
    !wrRst |=> rstCtl_q[3:0] == $past(rstCtl_q[3:0]))
    else $error("reset bits changed without write");
  a_phy_reset_or: assert property (@(posedge mclk) disable iff (rst)
    seqPhyS |=> !phyReset_n)
    else $error("sequencer phy reset lost");
  a_mem_good_and: assert property (@(posedge mclk) disable iff (rst)
    req.rd && req.addr == bsc_pkg::PwrStatOff |=> rdData[0] == $past(&pins.memGood))
    else $error("memory good not AND");
  a_wd_disable: assert property (@(posedge mclk) disable iff (rst)
    !seqCtl_q[bsc_pkg::WdEnBit] |=> wdCnt_q == 0)
    else $error("watchdog kept counting");
  a_seq_once: assert property (@(posedge mclk) disable iff (rst)
    seqSt_q == SeqDone && goBit |=> seqSt_q == SeqDone)
    else $error("sequencer reran");
  a_power_off: assert property (@(posedge mclk) disable iff (rst)
    seqCtl_q[bsc_pkg::PwrOffBit] |=> forcePowerOff)
    else $error("power off not forced");
  a_full_pulse_once: assert property (@(posedge mclk) disable iff (rst)
    fullSystemReset |=> !fullSystemReset)
    else $error("full reset pulse too long");
  a_slot_term_off: assert property (@(posedge mclk) disable iff (rst)
    !rstCtl_q[bsc_pkg::SlotSelBit] |=> !slotIntReset)
    else $error("slot reset without select");
  a_phy_reg_drive: assert property (@(posedge mclk) disable iff (rst)
    !rstCtl_q[bsc_pkg::PhyRelBit] |=> !phyReset_n)
    else $error("phy reset not driven by register");
  a_lb_reset_or: assert property (@(posedge mclk) disable iff (rst)
    seqLbS |=> !localBusReset_n)
    else $error("sequencer local bus reset lost");
  a_gen_reset_or: assert property (@(posedge mclk) disable iff (rst)
    seqGenS |=> !generalReset_n)
    else $error("sequencer general reset lost");
  a_scratch_keep: assert property (@(posedge mclk) disable iff (rst)
    !wrScr1 && !chassisRst |=> scr1_q == $past(scr1_q))
    else $error("scratch changed without write");
  a_seq_idle_hold: assert property (@(posedge mclk) disable iff (rst)
    seqSt_q == SeqIdle && !goBit |=> !seqBusy)
    else $error("sequencer left idle without start");
  a_busy_readback: assert property (@(posedge mclk) disable iff (rst)
    req.rd && req.addr == bsc_pkg::SeqStatOff |=> rdData[bsc_pkg::BusyBit] == $past(seqBusy))
    else $error("busy bit read wrong");
  a_reserved_zero: assert property (@(posedge mclk) disable iff (rst)
    (rstCtl_q & ~bsc_pkg::RstCtlMask) == 8'h00 && (seqCtl_q & ~bsc_pkg::SeqCtlMask) == 8'h00)
    else $error("reserved bit set");

endmodule

// ==== sim/bsc_regs_tb.sv ====
// Self-checking bench for the system control register bank
`timescale 1ns/1ps
module bsc_regs_tb;
  logic mclk, rst, chassisRst, mainG, core0G, serG, v12G, br18G, slotInt_n;
  logic seqPhy, seqLb, seqGen;
  logic [1:0] memG;
  logic [2:0] memClk, sysClk;
  bsc_pkg::bsc_req_t req;
  logic [7:0] rdData, v;
  logic fullRst, slotRst, phy_n, lb_n, gen_n, force_power_off, seqStart, seqBusy;
  int miscompares, n_checks, pulses, starts;
  logic [31:0] seed;

  bsc_regs #(.WdCycles(64), .SeqCycles(16)) dut (.mclk(mclk), .rst(rst),
    .chassisRst(chassisRst), .req(req), .rdData(rdData), .mainSupplyGood(mainG),
    .core0SupplyGood(core0G), .serialLinkSupplyGood(serG), .supply1v2Good(v12G),
    .bridge1v8Good(br18G), .memorySupplyGood(memG), .memoryClockSetting(memClk),
    .systemClockSetting(sysClk), .remoteSlotInt_n(slotInt_n), .seqPhyReset(seqPhy),
    .seqLocalBusReset(seqLb), .seqGeneralReset(seqGen), .fullSystemReset(fullRst),
    .slotIntReset(slotRst), .phyReset_n(phy_n), .localBusReset_n(lb_n),
    .generalReset_n(gen_n), .forcePowerOff(force_power_off), .seqStart(seqStart),
    .seqBusy(seqBusy));

  // ****************************************************************
  // Clock, pulse counters, helpers
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Pulses are counted on the edge so a one-cycle pulse is never missed
  always @(posedge mclk) begin
    if (fullRst === 1'b1) pulses++;
    if (seqStart === 1'b1) starts++;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected power byte, bit 0 of the register is the byte's MSB
  function automatic logic [7:0] pwrExp();
    return {mainG, core0G, 2'b00, serG, v12G, br18G, memG[1] & memG[0]};
  endfunction

  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [5:0] a, output logic [7:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    @(negedge mclk);
    d = rdData;
    // Return on a rising edge so later stimulus changes right after it
    @(posedge mclk);
  endtask

  task automatic rchk(string name, logic [5:0] a, logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(name, exp, d);
  endtask

  // Waits a bounded span for a pulse counter to move past a mark
  task automatic waitCnt(ref int cnt, input int mark, input int lim);
    for (int i = 0; i < lim && cnt == mark; i++) @(posedge mclk);
  endtask

  task test_done();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard sized well past the expected several hundred cycles
  initial begin
    #(20000 * 100);
    miscompares++;
    test_done();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed = 32'h934b;
    {rst, chassisRst, mainG, core0G, serG, v12G, br18G} = 7'b1000000;
    {seqPhy, seqLb, seqGen, memG, memClk, sysClk} = '0;
    slotInt_n = 1'b1;
    req = '0;
    cyc(5);
    rst <= 1'b0;
    // Second edge after release: the slot term must not flash from cleared flops
    cyc(2);
    chk("slot_idle", 8'h00, {7'h00, slotRst});
    cyc(2);
    // Reset values and quiet outputs
    rchk("rst_ctl", bsc_pkg::RstCtlOff, 8'h8f);
    rchk("seq_ctl", bsc_pkg::SeqCtlOff, 8'h00);
    rchk("seq_stat", bsc_pkg::SeqStatOff, 8'h00);
    rchk("scratch1", bsc_pkg::ScratchOneOff, 8'h00);
    rchk("unmapped", 6'h09, 8'h00);
    chk("pwr_off", 8'h00, {7'h00, force_power_off});
    chk("resets", 8'h07, {5'h00, phy_n, lb_n, gen_n});
    // Live status and switch report with random levels
    for (int i = 0; i < 8; i++) begin
      v = 8'(rnd());
      {mainG, core0G, serG, v12G, br18G, memG} <= v[6:0];
      {memClk, sysClk} <= 6'(rnd());
      cyc(4);
      rchk("pwr_stat", bsc_pkg::PwrStatOff, pwrExp());
      rchk("clk_rpt", bsc_pkg::ClkRptOff, {2'b00, memClk, sysClk});
    end
    wr(bsc_pkg::PwrStatOff, 8'hff);
    rchk("pwr_ro", bsc_pkg::PwrStatOff, pwrExp());
    // Reset control bits, ORed with the sequencer terms
    for (int i = 0; i < 12; i++) begin
      v = 8'(rnd()) | 8'h80;
      {seqPhy, seqLb, seqGen} <= 3'(rnd());
      slotInt_n <= 1'(rnd());
      wr(bsc_pkg::RstCtlOff, v);
      cyc(4);
      rchk("rst_rd", bsc_pkg::RstCtlOff, v & 8'h8f);
      chk("phy_n", {7'h00, v[2] & ~seqPhy}, {7'h00, phy_n});
      chk("lb_n", {7'h00, v[1] & ~seqLb}, {7'h00, lb_n});
      chk("gen_n", {7'h00, v[0] & ~seqGen}, {7'h00, gen_n});
      chk("slot", {7'h00, v[3] & ~slotInt_n}, {7'h00, slotRst});
    end
    {seqPhy, seqLb, seqGen, slotInt_n} <= 4'h1;
    // Full reset request pulses once and restores its bit
    wr(bsc_pkg::RstCtlOff, 8'h0f);
    waitCnt(pulses, 0, 6);
    cyc(3);
    chk("full_pulse", 8'h01, 8'(pulses));
    rchk("all_back", bsc_pkg::RstCtlOff, 8'h8f);
    // Scratch registers, then chassis reset clears them
    for (int i = 0; i < 6; i++) begin
      v = 8'(rnd());
      wr(bsc_pkg::ScratchOneOff, v);
      wr(bsc_pkg::ScratchTwoOff, ~v);
      rchk("scratch1", bsc_pkg::ScratchOneOff, v);
      rchk("scratch2", bsc_pkg::ScratchTwoOff, ~v);
    end
    chassisRst <= 1'b1;
    cyc(2);
    chassisRst <= 1'b0;
    rchk("chassis1", bsc_pkg::ScratchOneOff, 8'h00);
    rchk("chassis2", bsc_pkg::ScratchTwoOff, 8'h00);
    wr(bsc_pkg::ScratchOneOff, 8'h5a);
    // Watchdog fires after its count, scratch survives
    pulses = 0;
    wr(bsc_pkg::SeqCtlOff, 8'h08);
    cyc(50);
    chk("wd_early", 8'h00, 8'(pulses));
    waitCnt(pulses, 0, 40);
    chk("wd_fire", 8'h01, 8'(pulses));
    wr(bsc_pkg::SeqCtlOff, 8'h00);
    rchk("wd_keep", bsc_pkg::ScratchOneOff, 8'h5a);
    // Clearing the enable mid-count stops the timeout
    pulses = 0;
    wr(bsc_pkg::SeqCtlOff, 8'h08);
    cyc(30);
    wr(bsc_pkg::SeqCtlOff, 8'h00);
    cyc(150);
    chk("wd_stop", 8'h00, 8'(pulses));
    // Forced power off
    wr(bsc_pkg::SeqCtlOff, 8'hf6);
    cyc(2);
    chk("pwr_off", 8'h01, {7'h00, force_power_off});
    rchk("seq_rd", bsc_pkg::SeqCtlOff, 8'h02);
    // Sequencer runs once per start, then waits for the bit to drop
    for (int k = 0; k < 2; k++) begin
      starts = 0;
      wr(bsc_pkg::SeqCtlOff, 8'h03);
      waitCnt(starts, 0, 6);
      chk("seq_start", 8'h01, 8'(starts));
      rchk("busy_rd", bsc_pkg::SeqStatOff, 8'h01);
      for (int i = 0; i < 40 && seqBusy !== 1'b0; i++) @(posedge mclk);
      cyc(30);
      chk("seq_once", 8'h00, {7'h00, seqBusy});
      chk("seq_runs", 8'h01, 8'(starts));
      rchk("idle_rd", bsc_pkg::SeqStatOff, 8'h00);
      wr(bsc_pkg::SeqCtlOff, 8'h02);
    end
    test_done();
  end
endmodule
